// file: mrfpl_pkg.sv
// Constants and types for the mouse radio packet transmitter
package mrfpl_pkg;
	localparam int unsigned CLOCK_HZ = 10_000_000;
	localparam int unsigned TICK_NS = 104_000;
	// Longest time rounds down
	localparam int unsigned TICK_CYCLES = TICK_NS / (1_000_000_000 / CLOCK_HZ);
	localparam int unsigned PREAMBLE_LEN = 8;
	localparam logic [7:0] PREAMBLE_BITS = 8'h55;
	localparam int unsigned SYNC_LEN = 8;
	localparam logic [7:0] SYNC_BITS = 8'hd3;
	localparam int unsigned HEADER_LEN = 4;
	localparam logic [3:0] HEADER_XY = 4'h5;
	localparam logic [3:0] HEADER_BZ = 4'ha;
	// Level of the first half bit when the bit is 1; second half is inverted
	localparam logic MANCH_ONE_FIRST = 1'b1;
	localparam logic IDLE_LEVEL = 1'b0;
	localparam int unsigned BYTE_SLOTS = 9;
	localparam int unsigned ID_BUTTON_BIT = 3;
	localparam logic [7:0] ID_RESET = 8'h00;
	localparam int unsigned BUF_DEPTH = 2;
	typedef enum logic [2:0] {
		MRFPL_IDLE,
		MRFPL_PREAMBLE,
		MRFPL_SYNC,
		MRFPL_HEADER,
		MRFPL_BYTES,
		MRFPL_TAIL
	} mrfpl_state_type;
endpackage

// file: mrfpl_buffer.sv
// Two-entry valid/ready buffer for packet requests
`timescale 1ns/1ps
`default_nettype none
module mrfpl_buffer
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [16:0] in_data,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [16:0]      out_data
);
	logic [16:0] store [mrfpl_pkg::BUF_DEPTH];
	logic        wr_ptr;
	logic        rd_ptr;
	logic [1:0]  count;
	logic        push;
	logic        pop;
	logic [1:0]  next_count;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign next_count = 2'(count + {1'b0, push} - {1'b0, pop});
	assign out_valid = (count != 2'd0);
	assign out_data = store[rd_ptr];

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			store[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
			in_ready <= 1'b1;
		end
		else
		begin
			if (push)
			begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop)
			begin
				rd_ptr <= ~rd_ptr;
			end
			count <= next_count;
			// Registered so the ready output comes straight from a flip-flop
			in_ready <= (next_count != 2'd2);
		end
	end
endmodule
`default_nettype wire

// file: mrfpl_transmitter.sv
// Mouse radio packet framer, serialiser and Manchester line driver
`timescale 1ns/1ps
`default_nettype none
module mrfpl_transmitter
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       pkt_valid,
	output logic            pkt_ready,
	input  wire logic       pkt_is_button,
	input  wire logic [7:0] pkt_byte0,
	input  wire logic [7:0] pkt_byte1,
	input  wire logic [7:0] mouse_id,
	input  wire logic       id_load,
	output logic [7:0]      stored_id,
	output logic            radio_tx_bit_out,
	output logic            radio_power_down,
	output logic            tx_busy
);
	localparam logic [11:0] TICK_LAST = 12'(mrfpl_pkg::TICK_CYCLES - 1);

	mrfpl_pkg::mrfpl_state_type state;
	logic [11:0] tick_count;
	logic        tick;
	logic        half;
	logic [3:0]  bit_index;
	logic [1:0]  byte_index;
	logic [16:0] current;
	logic        buf_valid;
	logic        buf_ready;
	logic [16:0] buf_data;
	logic        data_bit;
	logic        take;
	logic [7:0]  cur_byte;
	logic        active;
	logic        next_level;

	function automatic logic [7:0] checksum(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] id);
		checksum = 8'(a + b + id);
	endfunction

	function automatic logic manchester(input logic b, input logic second_half);
		manchester = (b ? mrfpl_pkg::MANCH_ONE_FIRST : ~mrfpl_pkg::MANCH_ONE_FIRST) ^ second_half;
	endfunction

	// Stall here holds the request in the buffer rather than losing it
	mrfpl_buffer u_buffer
	(
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (pkt_valid),
		.in_ready  (pkt_ready),
		.in_data   ({pkt_is_button, pkt_byte1, pkt_byte0}),
		.out_valid (buf_valid),
		.out_ready (buf_ready),
		.out_data  (buf_data)
	);

	assign tick = (tick_count == TICK_LAST);
	assign take = tick && half && (state == mrfpl_pkg::MRFPL_IDLE) && buf_valid;
	assign buf_ready = take;

	// Byte 2 is the checksum, same sum for both packet types
	always_comb
	begin
		case (byte_index)
			2'd0: cur_byte = current[7:0];
			2'd1: cur_byte = current[15:8];
			default: cur_byte = checksum(current[7:0], current[15:8], stored_id);
		endcase
	end

	always_comb
	begin
		case (state)
			mrfpl_pkg::MRFPL_PREAMBLE: data_bit = mrfpl_pkg::PREAMBLE_BITS[bit_index[2:0]];
			mrfpl_pkg::MRFPL_SYNC: data_bit = mrfpl_pkg::SYNC_BITS[bit_index[2:0]];
			mrfpl_pkg::MRFPL_HEADER: data_bit = current[16] ? mrfpl_pkg::HEADER_BZ[bit_index[1:0]]
				: mrfpl_pkg::HEADER_XY[bit_index[1:0]];
			// Slot 8 is the stop bit
			mrfpl_pkg::MRFPL_BYTES: data_bit = (bit_index == 4'd8) ? 1'b1
				: cur_byte[bit_index[2:0]];
			default: data_bit = mrfpl_pkg::IDLE_LEVEL;
		endcase
	end

	assign active = (state != mrfpl_pkg::MRFPL_IDLE) && (state != mrfpl_pkg::MRFPL_TAIL);
	// Level is decided one tick ahead, like an output compare
	assign next_level = active ? manchester(data_bit, half) : mrfpl_pkg::IDLE_LEVEL;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tick_count <= 12'h000;
		end
		else if (tick)
		begin
			tick_count <= 12'h000;
		end
		else
		begin
			tick_count <= 12'(tick_count + 12'h001);
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stored_id <= mrfpl_pkg::ID_RESET;
		end
		else if (id_load)
		begin
			stored_id <= mouse_id;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			radio_tx_bit_out <= mrfpl_pkg::IDLE_LEVEL;
			radio_power_down <= 1'b1;
		end
		else if (tick)
		begin
			radio_tx_bit_out <= next_level;
			// Radio stays off outside frames to save battery
			radio_power_down <= ~(active || take);
		end
	end

	// Busy tracks the radio enable, so the tail bit never shows busy with the radio off
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_busy <= 1'b0;
		end
		else if (tick)
		begin
			tx_busy <= active || take;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= mrfpl_pkg::MRFPL_IDLE;
			half <= 1'b0;
			bit_index <= 4'd0;
			byte_index <= 2'd0;
			current <= 17'h0_0000;
		end
		else if (tick)
		begin
			half <= ~half;
			if (half)
			begin
				bit_index <= 4'(bit_index + 4'd1);
				case (state)
					mrfpl_pkg::MRFPL_IDLE:
					begin
						if (buf_valid)
						begin
							current <= buf_data;
							state <= mrfpl_pkg::MRFPL_PREAMBLE;
							bit_index <= 4'd0;
						end
					end
					mrfpl_pkg::MRFPL_PREAMBLE:
					begin
						if (bit_index == 4'(mrfpl_pkg::PREAMBLE_LEN - 1))
						begin
							state <= mrfpl_pkg::MRFPL_SYNC;
							bit_index <= 4'd0;
						end
					end
					mrfpl_pkg::MRFPL_SYNC:
					begin
						if (bit_index == 4'(mrfpl_pkg::SYNC_LEN - 1))
						begin
							state <= mrfpl_pkg::MRFPL_HEADER;
							bit_index <= 4'd0;
						end
					end
					mrfpl_pkg::MRFPL_HEADER:
					begin
						if (bit_index == 4'(mrfpl_pkg::HEADER_LEN - 1))
						begin
							state <= mrfpl_pkg::MRFPL_BYTES;
							bit_index <= 4'd0;
							byte_index <= 2'd0;
						end
					end
					mrfpl_pkg::MRFPL_BYTES:
					begin
						if (bit_index == 4'(mrfpl_pkg::BYTE_SLOTS - 1))
						begin
							bit_index <= 4'd0;
							byte_index <= 2'(byte_index + 2'd1);
							if (byte_index == 2'd2)
							begin
								state <= mrfpl_pkg::MRFPL_TAIL;
							end
						end
					end
					mrfpl_pkg::MRFPL_TAIL:
					begin
						// One idle bit lets the last half bit reach the pin
						state <= mrfpl_pkg::MRFPL_IDLE;
					end
					default:
					begin
						state <= mrfpl_pkg::MRFPL_IDLE;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: mrfpl_chk.sv
// Port checker for the radio packet transmitter
`timescale 1ns/1ps
`default_nettype none
module mrfpl_chk
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       pkt_valid,
	input wire logic       pkt_ready,
	input wire logic       pkt_is_button,
	input wire logic [7:0] pkt_byte0,
	input wire logic [7:0] pkt_byte1,
	input wire logic [7:0] mouse_id,
	input wire logic       id_load,
	input wire logic [7:0] stored_id,
	input wire logic       radio_tx_bit_out,
	input wire logic       radio_power_down,
	input wire logic       tx_busy
);
	localparam int unsigned T = mrfpl_pkg::TICK_CYCLES;
	logic [31:0] gap;
	logic        seen;
	// Wide gap so long idle never wraps
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gap <= 32'h0000_0001;
			seen <= 1'b0;
		end
		else if ($changed(radio_tx_bit_out) || $changed(radio_power_down))
		begin
			gap <= 32'h0000_0001;
			seen <= 1'b1;
		end
		else
			gap <= gap + 32'h0000_0001;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	reset_state_a: assert property ($rose(reset_n) |-> pkt_ready && radio_power_down)
		else $error("outputs wrong after reset");
	id_store_a: assert property (id_load |=> stored_id == $past(mouse_id))
		else $error("identifier not stored");
	id_hold_a: assert property (!id_load |=> $stable(stored_id))
		else $error("identifier changed unasked");
	idle_line_a: assert property (radio_power_down |-> !radio_tx_bit_out)
		else $error("line not idle while radio off");
	tick_edge_a: assert property (($changed(radio_tx_bit_out) || $changed(radio_power_down))
		&& seen |-> gap % T == 0)
		else $error("line moved off the tick");
	bit_run_a: assert property (!radio_power_down && !$past(radio_power_down)
		|-> gap <= 2 * T)
		else $error("no Manchester transition");
	busy_on_a: assert property (tx_busy |-> !radio_power_down)
		else $error("radio off while busy");
	lead_idle_a: assert property ($fell(radio_power_down) |-> !radio_tx_bit_out [*8])
		else $error("frame began before next tick");
endmodule
bind mrfpl_transmitter mrfpl_chk mrfpl_chk_i (.clk, .reset_n, .pkt_valid, .pkt_ready,
	.pkt_is_button, .pkt_byte0, .pkt_byte1, .mouse_id, .id_load, .stored_id,
	.radio_tx_bit_out, .radio_power_down, .tx_busy);
`default_nettype wire

// file: mrfpl_rx_model.sv
// Receiver model that decodes one frame per radio power-up
`timescale 1ns/1ps
`default_nettype none
module mrfpl_rx_model
(
	input  wire logic        clk,
	input  wire logic        radio_tx_bit_out,
	input  wire logic        radio_power_down,
	input  wire logic        suspended,
	input  wire logic [7:0]  pair_id,
	output logic [7:0]       frames,
	output logic [7:0]       faults,
	output logic [7:0]       wakes,
	output logic [46:0]      bits
);
	localparam int unsigned T = mrfpl_pkg::TICK_CYCLES;
	int   i;
	logic a;
	logic cut;
	logic sum_ok;
	initial
	begin
		frames = 8'h00;
		faults = 8'h00;
		wakes = 8'h00;
		bits = '0;
		forever
		begin
			@(negedge radio_power_down);
			cut = 1'b0;
			// Mid-tick sampling tolerates edge jitter
			repeat (T + T / 2) @(posedge clk);
			for (i = 0; i < 47; i++)
			begin
				a = radio_tx_bit_out;
				repeat (T) @(posedge clk);
				cut = cut | radio_power_down;
				faults = faults + 8'(a === radio_tx_bit_out);
				bits[i] = a === mrfpl_pkg::MANCH_ONE_FIRST;
				// No wait after the last bit, so the next frame start is not missed
				if (i < 46)
				begin
					repeat (T) @(posedge clk);
				end
			end
			sum_ok = bits[45:38] == 8'(bits[27:20] + bits[36:29] + pair_id);
			// Cut or corrupt frames are dropped, neither queued nor waking
			if (!cut && sum_ok && suspended)
			begin
				wakes = wakes + 8'h01;
			end
			else if (!cut && sum_ok)
			begin
				frames = frames + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench.sv
// Random and corner-case bench for the radio transmitter
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, reset_n, pkt_valid, pkt_is_button, id_load, abtn, suspended;
	logic [7:0]  pkt_byte0, pkt_byte1, mouse_id, id, a0, a1;
	wire         pkt_ready, radio_tx_bit_out, radio_power_down, tx_busy;
	wire  [7:0]  stored_id, frames, faults, wakes;
	wire  [46:0] bits;
	int          err_count, samples_checked, n;
	mrfpl_transmitter mrfpl_transmitter_i (.clk, .reset_n, .pkt_valid, .pkt_ready,
		.pkt_is_button, .pkt_byte0, .pkt_byte1, .mouse_id, .id_load, .stored_id,
		.radio_tx_bit_out, .radio_power_down, .tx_busy);
	mrfpl_rx_model mrfpl_rx_model_i (.clk, .radio_tx_bit_out, .radio_power_down,
		.suspended, .pair_id (id), .frames, .faults, .wakes, .bits);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task check(input logic [63:0] seen, input logic [63:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			err_count++;
			$display("wrong value at %0t: %h expected %h", $time, seen, want);
		end
	endtask
	task results;
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	function logic [46:0] frame(input logic btn, input logic [7:0] b0, b1, idv);
		logic [7:0] s;
		s = b0 + b1 + idv;
		return {1'b1, s, 1'b1, b1, 1'b1, b0, btn ? mrfpl_pkg::HEADER_BZ :
			mrfpl_pkg::HEADER_XY, mrfpl_pkg::SYNC_BITS, mrfpl_pkg::PREAMBLE_BITS};
	endfunction
	// Leaves valid high so back-to-back calls keep the queue busy
	task send(input logic btn, input logic [7:0] b0, b1);
		pkt_valid = 1'b1;
		pkt_is_button = btn;
		pkt_byte0 = b0;
		pkt_byte1 = b1;
		for (n = 0; n < 3000 && pkt_ready !== 1'b1; n++)
			@(negedge clk);
		if (pkt_ready !== 1'b1)
		begin
			err_count++;
		end
		@(negedge clk);
	endtask
	initial
	begin
		err_count = 0;
		samples_checked = 0;
		{reset_n, pkt_valid, pkt_is_button, id_load, suspended} = 5'h00;
		{pkt_byte0, pkt_byte1, mouse_id} = 24'h00_0000;
		n = $urandom(32'h5fe6_7872);
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		id = 8'($urandom);
		mouse_id = id;
		id_load = 1'b1;
		@(negedge clk);
		id_load = 1'b0;
		mouse_id = ~id;
		@(negedge clk);
		check(stored_id, id);
		abtn = 1'($urandom);
		a0 = 8'($urandom);
		a1 = 8'($urandom);
		a0[mrfpl_pkg::ID_BUTTON_BIT] = abtn;
		send(abtn, a0, a1);
		send(~abtn, 8'h80, 8'h7f);
		check(pkt_ready, 1'b0);
		send(1'b0, 8'hff, 8'h01);
		pkt_valid = 1'b0;
		for (n = 0; n < 100000 && frames !== 8'h01; n++)
		begin
			if (n == 50000)
			begin
				check(radio_power_down, 1'b0);
				check(tx_busy, 1'b1);
			end
			@(negedge clk);
		end
		check(frames, 8'h01);
		check(wakes, 8'h00);
		check(bits, frame(abtn, a0, a1, id));
		check(faults, 8'h00);
		results;
	end
endmodule
`default_nettype wire
